// [design/osr_top.sv]
// Option select register bank with its strobes, pins and ready control.
`timescale 1ns/10ps
`default_nettype none
module osr_top
    import osr_pkg::*;
#(
    parameter bit DMA_VARIANT = 1'b0
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic slot_setup_select_n_i,
    input wire logic io_rd_i,
    input wire logic io_wr_i,
    input wire logic [15:0] io_addr_i,
    input wire logic [7:0] io_wdata_i,
    output logic [7:0] io_rdata_o,
    output logic io_rdata_oe_o,
    input wire logic channel_reset_i,
    input wire logic pin_configuration_strap_i,
    input wire logic pin_mode_one_i,
    input wire logic error_n_i,
    input wire logic extra_status_flag_n_i,
    input wire logic [1:0] block_a_address_inputs_i,
    input wire logic adapter_ready_n_i,
    input wire logic ready_strobe_i,
    input wire logic command_n_i,
    output logic id_low_read_strobe_n_o,
    output logic id_high_read_strobe_n_o,
    output logic [7:0] ext_strobe_n_o,
    output logic card_enabled_out_o,
    output logic user_out_six_o,
    output logic user_out_seven_o,
    output logic [4:0] user_out_one_to_five_o,
    output logic [3:0] open_collector_user_outs_o,
    output logic [3:0] open_collector_user_outs_oe_o,
    output logic [3:0] arb_level_o,
    output logic fair_enable_o,
    output logic block_a_match_n_o,
    output logic channel_check_line_o,
    output logic channel_ready_line_o,
    output logic normal_mode_en_o
);

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    // Pins other than address and write data pass two flops that reset to idle levels, so no false edge follows.
    localparam int SYNC_W = 13;
    logic [SYNC_W-1:0] sync_meta_r;
    logic [SYNC_W-1:0] sync_r;
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            sync_meta_r <= OSR_RST_SYNC;
            sync_r <= OSR_RST_SYNC;
        end else begin
            sync_meta_r <= {slot_setup_select_n_i, io_rd_i, io_wr_i, channel_reset_i,
                            pin_configuration_strap_i, pin_mode_one_i, error_n_i,
                            extra_status_flag_n_i, block_a_address_inputs_i,
                            adapter_ready_n_i, ready_strobe_i, command_n_i};
            sync_r <= sync_meta_r;
        end
    end
    logic setup_n_s;
    logic rd_s;
    logic wr_s;
    logic channel_reset_s;
    logic strap_s;
    logic mode_one_s;
    logic error_n_s;
    logic extra_n_s;
    logic [1:0] aa_s;
    logic adp_rdy_n_s;
    logic rdy_stb_s;
    logic cmd_n_s;
    assign {setup_n_s, rd_s, wr_s, channel_reset_s, strap_s, mode_one_s, error_n_s,
            extra_n_s, aa_s, adp_rdy_n_s, rdy_stb_s, cmd_n_s} = sync_r;

    // ------------------------------------------------------------
    // Pin mode and address decode
    // ------------------------------------------------------------
    // A strap tied to channel reset is low outside that reset, so mode 2 is
    // latched while it is high; a new strap is seen at the next channel reset.
    logic mode2_r;
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            mode2_r <= 1'b0;
        end else if (channel_reset_s) begin
            mode2_r <= strap_s && !mode_one_s;
        end
    end

    logic in_setup;
    logic addr_hit;
    logic [2:0] reg_sel;
    logic rd_edge;
    logic wr_edge;
    logic rd_q_r;
    logic wr_q_r;
    assign in_setup = ~setup_n_s;
    assign addr_hit = in_setup && (io_addr_i[15:3] == OSR_ADDR_BASE_HI);
    assign reg_sel = io_addr_i[2:0];
    assign rd_edge = rd_s && !rd_q_r;
    assign wr_edge = wr_s && !wr_q_r;
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            rd_q_r <= 1'b0;
            wr_q_r <= 1'b0;
        end else begin
            rd_q_r <= rd_s;
            wr_q_r <= wr_s;
        end
    end

    logic int_103;
    logic int_104;
    assign int_103 = !mode2_r;
    assign int_104 = !mode2_r && !mode_one_s;

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    logic [7:0] enable_r;
    logic [7:0] reloc_a_r;
    logic [7:0] reloc_b_r;
    logic [5:0] status_r;
    logic check_n_r;
    logic do_wr;
    assign do_wr = addr_hit && wr_edge;

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            enable_r <= OSR_RST_ENABLE;
        end else if (channel_reset_s) begin
            enable_r <= OSR_RST_ENABLE;
        end else if (do_wr && reg_sel == OSR_ADDR_ENABLE[2:0]) begin
            enable_r <= io_wdata_i;
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            reloc_a_r <= OSR_RST_RELOC;
            reloc_b_r <= OSR_RST_RELOC;
        end else if (channel_reset_s) begin
            reloc_a_r <= OSR_RST_RELOC;
            reloc_b_r <= OSR_RST_RELOC;
        end else if (do_wr) begin
            if (reg_sel == OSR_ADDR_RELOC_A[2:0] && int_103) begin
                reloc_a_r <= io_wdata_i;
            end
            if (reg_sel == OSR_ADDR_RELOC_B[2:0] && int_104) begin
                reloc_b_r <= io_wdata_i;
            end
        end
    end

    // Bits 5:0 of the status register are writable in every variant.
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            status_r <= OSR_RST_STATUS[5:0];
        end else if (channel_reset_s) begin
            status_r <= OSR_RST_STATUS[5:0];
        end else if (do_wr && reg_sel == OSR_ADDR_STATUS[2:0]) begin
            status_r <= io_wdata_i[5:0];
        end
    end

    // The check flag stays low until a reset; a live error wins over channel reset.
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            check_n_r <= OSR_RST_STATUS[OSR_BIT_CHECK];
        end else if (!error_n_s) begin
            check_n_r <= 1'b0;
        end else if (channel_reset_s) begin
            check_n_r <= OSR_RST_STATUS[OSR_BIT_CHECK];
        end
    end

    // ------------------------------------------------------------
    // Read path and strobes
    // ------------------------------------------------------------
    logic [7:0] rdata_nxt;
    logic rdata_oe_nxt;
    osr_strobe_t stb_nxt;
    logic do_rd;
    assign do_rd = addr_hit && rd_s;
    always_comb begin
        rdata_nxt = 8'h00;
        rdata_oe_nxt = 1'b0;
        stb_nxt = '0;
        if (do_rd) begin
            case (reg_sel)
                3'h0: stb_nxt.id_low_rd = 1'b1;
                3'h1: stb_nxt.id_high_rd = 1'b1;
                3'h2: begin
                    rdata_nxt = enable_r;
                    rdata_oe_nxt = 1'b1;
                end
                3'h3: begin
                    if (int_103) begin
                        rdata_nxt = reloc_a_r;
                        rdata_oe_nxt = 1'b1;
                    end else begin
                        stb_nxt.reloc_a_rd = 1'b1;
                    end
                end
                3'h4: begin
                    if (int_104) begin
                        rdata_nxt = reloc_b_r;
                        rdata_oe_nxt = 1'b1;
                    end else begin
                        stb_nxt.reloc_b_rd = 1'b1;
                    end
                end
                3'h5: begin
                    rdata_nxt = {check_n_r, mode2_r && extra_n_s, status_r};
                    rdata_oe_nxt = 1'b1;
                end
                3'h6: stb_nxt.extra_lo_rd = mode2_r;
                3'h7: stb_nxt.extra_hi_rd = mode2_r;
                default: ;
            endcase
        end
        if (addr_hit && wr_s) begin
            case (reg_sel)
                3'h3: stb_nxt.reloc_a_wr = !int_103;
                3'h4: stb_nxt.reloc_b_wr = !int_104;
                3'h6: stb_nxt.extra_lo_wr = mode2_r;
                3'h7: stb_nxt.extra_hi_wr = mode2_r;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            io_rdata_o <= 8'h00;
            io_rdata_oe_o <= 1'b0;
            id_low_read_strobe_n_o <= 1'b1;
            id_high_read_strobe_n_o <= 1'b1;
            ext_strobe_n_o <= 8'hff;
        end else begin
            io_rdata_o <= rdata_nxt;
            io_rdata_oe_o <= rdata_oe_nxt;
            id_low_read_strobe_n_o <= !stb_nxt.id_low_rd;
            id_high_read_strobe_n_o <= !stb_nxt.id_high_rd;
            ext_strobe_n_o <= ~{stb_nxt.extra_hi_rd, stb_nxt.extra_hi_wr,
                                stb_nxt.extra_lo_rd, stb_nxt.extra_lo_wr,
                                stb_nxt.reloc_a_rd, stb_nxt.reloc_a_wr,
                                stb_nxt.reloc_b_rd, stb_nxt.reloc_b_wr};
        end
    end

    // ------------------------------------------------------------
    // User pins, match and check
    // ------------------------------------------------------------
    // Open-collector pins only pull low; a one is left to the pull-up.
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            card_enabled_out_o <= 1'b0;
            normal_mode_en_o <= 1'b0;
            user_out_six_o <= 1'b0;
            user_out_seven_o <= 1'b0;
            user_out_one_to_five_o <= 5'h00;
            open_collector_user_outs_o <= 4'h0;
            open_collector_user_outs_oe_o <= 4'h0;
            arb_level_o <= 4'h0;
            fair_enable_o <= 1'b0;
            block_a_match_n_o <= 1'b1;
            channel_check_line_o <= 1'b0;
        end else begin
            card_enabled_out_o <= enable_r[OSR_BIT_CARD_EN];
            normal_mode_en_o <= enable_r[OSR_BIT_CARD_EN] && setup_n_s;
            user_out_six_o <= enable_r[6];
            user_out_seven_o <= enable_r[7];
            user_out_one_to_five_o <= DMA_VARIANT ? 5'h00 : enable_r[5:1];
            open_collector_user_outs_o <= 4'h0;
            open_collector_user_outs_oe_o <= DMA_VARIANT ? 4'h0 : ~status_r[3:0];
            arb_level_o <= DMA_VARIANT ? status_r[3:0] : 4'h0;
            fair_enable_o <= DMA_VARIANT && !status_r[OSR_BIT_FAIR];
            block_a_match_n_o <= !(int_103 && aa_s == reloc_a_r[7:6]);
            channel_check_line_o <= !error_n_s && enable_r[OSR_BIT_CARD_EN];
        end
    end

    // ------------------------------------------------------------
    // Channel ready
    // ------------------------------------------------------------
    // Ready is held low on an adapter wait; the sync bit picks its release.
    logic cmd_q_r;
    logic rdy_stb_q_r;
    logic wait_r;
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            cmd_q_r <= 1'b1;
            rdy_stb_q_r <= 1'b0;
            wait_r <= 1'b0;
            channel_ready_line_o <= 1'b1;
        end else begin
            cmd_q_r <= cmd_n_s;
            rdy_stb_q_r <= rdy_stb_s;
            if (!enable_r[OSR_BIT_CARD_EN] || !setup_n_s) begin
                wait_r <= 1'b0;
            end else if (status_r[OSR_BIT_SYNC_RDY] && cmd_q_r && !cmd_n_s) begin
                wait_r <= 1'b0;
            end else if (!status_r[OSR_BIT_SYNC_RDY] && rdy_stb_s && !rdy_stb_q_r) begin
                wait_r <= 1'b0;
            end else if (!adp_rdy_n_s && cmd_n_s) begin
                wait_r <= 1'b1;
            end
            channel_ready_line_o <= !wait_r;
        end
    end

endmodule // osr_top
`default_nettype wire

// [design/osr_pkg.sv]
// Constants and carrier types for the option select register block.
// Behaviour
// - Setup mode while slot setup select low; registers answer only then.
// - In setup mode decode configuration registers at I/O 100h..107h.
// - Card identifier low byte at 100h, high byte at 101h.
// - Separate read strobes for 100h and 101h; external store drives only then.
// - Bit 0 of 102h written 0 disables card, 1 enables it.
// - Card enable low suppresses normal-mode enable, channel check and ready wait, but not the block match output.
// - Card enable bit drives an output pin continuously, high means enabled.
// - Channel reset clears card enable and its pin.
// - Bits 6 and 7 of 102h drive pins, cleared by channel reset.
// - Non-DMA variant brings bits 1..5 of 102h to pins; DMA variant not.
// - 103h internal in pin modes 0 and 1, external in mode 2.
// - 104h internal only in pin mode 0, external otherwise.
// - 105h always internal in every mode and variant.
// - 105h bit 5 high releases ready on command edge, low asynchronously.
// - 105h bit 6 read-only extra status in mode 2, else reads 0.
// - 105h bit 7 reads low after error input, set to 1 by reset.
// - DMA variant: 105h bits 0..3 hold arbitration level.
// - DMA variant: 105h bit 4 low enables fair arbitration.
// - Non-DMA variant: 105h bits 0..3 drive open-collector pins.
// - Non-DMA variant: 105h bit 4 is plain storage, no pin.
// - 106h and 107h external; strobes for them in pin mode 2 only.
// - Error input low asserts channel check and latches the check flag.
// - Modes 0 and 1 compare address inputs with 103h bits 7:6, low on match.
package osr_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [15:0] OSR_ADDR_ID_LOW = 16'h0100;
    localparam logic [15:0] OSR_ADDR_ID_HIGH = 16'h0101;
    localparam logic [15:0] OSR_ADDR_ENABLE = 16'h0102;
    localparam logic [15:0] OSR_ADDR_RELOC_A = 16'h0103;
    localparam logic [15:0] OSR_ADDR_RELOC_B = 16'h0104;
    localparam logic [15:0] OSR_ADDR_STATUS = 16'h0105;
    localparam logic [15:0] OSR_ADDR_EXTRA_LO = 16'h0106;
    localparam logic [15:0] OSR_ADDR_EXTRA_HI = 16'h0107;
    localparam logic [12:0] OSR_ADDR_BASE_HI = 13'h0020;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int OSR_BIT_CARD_EN = 0;
    localparam int OSR_BIT_FAIR = 4;
    localparam int OSR_BIT_SYNC_RDY = 5;
    localparam int OSR_BIT_EXTRA_ST = 6;
    localparam int OSR_BIT_CHECK = 7;
    localparam logic [7:0] OSR_RST_ENABLE = 8'h00;
    localparam logic [7:0] OSR_RST_RELOC = 8'h00;
    localparam logic [7:0] OSR_RST_STATUS = 8'h80;
    localparam logic [12:0] OSR_RST_SYNC = 13'h1065;

    // ------------------------------------------------------------
    // Pin modes and carriers
    // ------------------------------------------------------------
    localparam logic [1:0] OSR_MODE_0 = 2'h0;
    localparam logic [1:0] OSR_MODE_1 = 2'h1;
    localparam logic [1:0] OSR_MODE_2 = 2'h2;

    typedef struct packed {
        logic id_low_rd;
        logic id_high_rd;
        logic reloc_a_rd;
        logic reloc_a_wr;
        logic reloc_b_rd;
        logic reloc_b_wr;
        logic extra_lo_rd;
        logic extra_lo_wr;
        logic extra_hi_rd;
        logic extra_hi_wr;
    } osr_strobe_t;

endpackage : osr_pkg

// [verif/osr_top_properties.sv]
// Concurrent checks on the ports of the option select register block.
`timescale 1ns/10ps
`default_nettype none
module osr_top_properties
    import osr_pkg::*;
#(
    parameter bit DMA_VARIANT = 1'b0
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic slot_setup_select_n_i,
    input wire logic io_rd_i,
    input wire logic io_wr_i,
    input wire logic [15:0] io_addr_i,
    input wire logic [7:0] io_wdata_i,
    input wire logic io_rdata_oe_o,
    input wire logic channel_reset_i,
    input wire logic error_n_i,
    input wire logic id_low_read_strobe_n_o,
    input wire logic [7:0] ext_strobe_n_o,
    input wire logic card_enabled_out_o,
    input wire logic user_out_six_o,
    input wire logic user_out_seven_o,
    input wire logic [3:0] open_collector_user_outs_o,
    input wire logic [3:0] arb_level_o,
    input wire logic fair_enable_o,
    input wire logic channel_check_line_o,
    input wire logic normal_mode_en_o
);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (rst_i);

    // Pins take two sync flops and a register: causes sit three edges back.
    AST_SETUP_ONLY: assert property ($rose(io_rdata_oe_o) |-> $past(!slot_setup_select_n_i && io_rd_i, 3))
        else $error("read data driven outside a setup read");
    AST_ADDR_RANGE: assert property ($rose(io_rdata_oe_o) |-> $past(io_addr_i[15:3] == OSR_ADDR_BASE_HI, 3))
        else $error("read data driven for a foreign address");
    AST_ID_STROBE: assert property ($fell(id_low_read_strobe_n_o) |-> $past(io_rd_i && io_addr_i == OSR_ADDR_ID_LOW, 3))
        else $error("identifier strobe without its read");
    AST_ID_NO_DRIVE: assert property (!id_low_read_strobe_n_o |-> !io_rdata_oe_o)
        else $error("device drives data during identifier read");
    AST_ENABLE_SET: assert property ($rose(card_enabled_out_o)
        |-> $past(io_wr_i && io_wdata_i[OSR_BIT_CARD_EN] && io_addr_i == OSR_ADDR_ENABLE, 3))
        else $error("card enable rose without a write");
    AST_CHANNEL_RESET_CLEAR: assert property (channel_reset_i [*5]
        |-> !card_enabled_out_o && !user_out_six_o && !user_out_seven_o)
        else $error("channel reset left stored pins set");
    AST_DISABLED_QUIET: assert property (!card_enabled_out_o && $past(!card_enabled_out_o)
        |-> !normal_mode_en_o && !channel_check_line_o)
        else $error("normal signals while card disabled");
    AST_CHECK_LINE: assert property (!error_n_i && card_enabled_out_o |-> ##[0:3] channel_check_line_o)
        else $error("error input did not raise channel check");
    AST_PIN_LEVELS: assert property (open_collector_user_outs_o == 4'h0
        && (DMA_VARIANT || (arb_level_o == 4'h0 && !fair_enable_o)))
        else $error("variant pins at wrong level");
    AST_EXT_WRITE: assert property ($fell(ext_strobe_n_o[4]) |-> $past(io_wr_i && io_addr_i == OSR_ADDR_EXTRA_LO, 3))
        else $error("external write strobe without its write");

    COV_READ: cover property ($rose(io_rdata_oe_o));
    COV_ID: cover property ($fell(id_low_read_strobe_n_o));
    COV_CHECK: cover property ($rose(channel_check_line_o));
endmodule // osr_top_properties

bind osr_top osr_top_properties #(.DMA_VARIANT(DMA_VARIANT)) i_osr_props (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .slot_setup_select_n_i(slot_setup_select_n_i), .io_rd_i(io_rd_i), .io_wr_i(io_wr_i), .io_addr_i(io_addr_i),
    .io_wdata_i(io_wdata_i), .io_rdata_oe_o(io_rdata_oe_o), .channel_reset_i(channel_reset_i),
    .error_n_i(error_n_i), .id_low_read_strobe_n_o(id_low_read_strobe_n_o), .ext_strobe_n_o(ext_strobe_n_o),
    .card_enabled_out_o(card_enabled_out_o), .user_out_six_o(user_out_six_o), .user_out_seven_o(user_out_seven_o),
    .open_collector_user_outs_o(open_collector_user_outs_o), .arb_level_o(arb_level_o),
    .fair_enable_o(fair_enable_o), .channel_check_line_o(channel_check_line_o),
    .normal_mode_en_o(normal_mode_en_o));
`default_nettype wire

// [verif/osr_id_store.sv]
// Behavioural model of the external card identifier store.
`timescale 1ns/10ps
`default_nettype none
module osr_id_store #(
    parameter logic [15:0] CARD_ID = 16'h6a5c // Arbitrary value of our own.
) (
    input wire logic clk_sys_i,
    input wire logic id_low_read_strobe_n_i,
    input wire logic id_high_read_strobe_n_i,
    input wire logic id_ready_i,
    output logic [7:0] id_bus_o,
    output logic id_bus_oe_o
);
    logic [7:0] last_r;
    logic [15:0] id_value;

    // A store not yet ready answers zero.
    assign id_value = id_ready_i ? CARD_ID : 16'h0000;
    assign id_bus_oe_o = !id_low_read_strobe_n_i || !id_high_read_strobe_n_i;
    // Off the strobe the bus floats: show the inverse of the last byte.
    assign id_bus_o = !id_low_read_strobe_n_i ? id_value[7:0] :
                      !id_high_read_strobe_n_i ? id_value[15:8] : ~last_r;

    always_ff @(posedge clk_sys_i) begin
        if (id_bus_oe_o) begin
            last_r <= id_bus_o;
        end
    end
endmodule // osr_id_store
`default_nettype wire

// [verif/test_option_select_registers.sv]
// Self-checking testbench for the option select register block.
`timescale 1ns/10ps
`default_nettype none
module test_option_select_registers;
    import osr_pkg::*;
    localparam logic [15:0] TB_ID = 16'h6a5c; // Arbitrary value of our own.
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic setup_n = 1'b1, rd = 1'b0, wr = 1'b0, chrst = 1'b0, err_n = 1'b1, xst_n = 1'b1;
    logic ardy_n = 1'b1, rstb = 1'b0, cmd_n = 1'b1, id_rdy = 1'b0, snap_oe, m;
    logic prev_oe = 1'b0, prev_lo = 1'b1, prev_hi = 1'b1;
    logic [15:0] addr = 16'h0100;
    logic [15:0] ra[4] = '{16'h0103, 16'h0104, 16'h0106, 16'h0107};
    logic [7:0] wd = 8'h00, v, s, q, snap_xs, rdata, xs_n, id_bus;
    logic [1:0] aa = 2'h0, mode = 2'h0;
    logic oe, id_lo_n, id_hi_n, cen, u6, u7, fair, match_n, chk, rdy, nme, id_oe;
    logic [4:0] u15;
    logic [3:0] oc, oc_oe, arb;
    logic [7:0] exp_q[$];
    int rb[4] = '{3, 1, 5, 7};
    int failures = 0, total_checks = 0, cycles = 0;
    integer seed = 32'h7592_8940;
    // Straps: ground, supply or channel reset for modes 0, 1, 2.
    wire logic strap = (mode == 2'h2) ? chrst : mode[0];
    wire logic pm1 = (mode == 2'h1);

    osr_top #(.DMA_VARIANT(1'b0)) i_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .slot_setup_select_n_i(setup_n),
        .io_rd_i(rd), .io_wr_i(wr), .io_addr_i(addr), .io_wdata_i(wd), .io_rdata_o(rdata), .io_rdata_oe_o(oe),
        .channel_reset_i(chrst), .pin_configuration_strap_i(strap), .pin_mode_one_i(pm1), .error_n_i(err_n),
        .extra_status_flag_n_i(xst_n), .block_a_address_inputs_i(aa), .adapter_ready_n_i(ardy_n),
        .ready_strobe_i(rstb), .command_n_i(cmd_n), .id_low_read_strobe_n_o(id_lo_n),
        .id_high_read_strobe_n_o(id_hi_n), .ext_strobe_n_o(xs_n), .card_enabled_out_o(cen), .user_out_six_o(u6),
        .user_out_seven_o(u7), .user_out_one_to_five_o(u15), .open_collector_user_outs_o(oc),
        .open_collector_user_outs_oe_o(oc_oe), .arb_level_o(arb), .fair_enable_o(fair),
        .block_a_match_n_o(match_n), .channel_check_line_o(chk), .channel_ready_line_o(rdy),
        .normal_mode_en_o(nme));
    osr_id_store #(.CARD_ID(TB_ID)) i_id (.clk_sys_i(clk_sys_i), .id_low_read_strobe_n_i(id_lo_n),
        .id_high_read_strobe_n_i(id_hi_n), .id_ready_i(id_rdy), .id_bus_o(id_bus), .id_bus_oe_o(id_oe));

    always #12.5 clk_sys_i = ~clk_sys_i;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic test_done;
        $display("%0d checks, %0d failures", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask

    task automatic note(input string n);
        $display("test %s done", n);
    endtask

    // One host cycle, held and spaced for the sync chain.
    task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d, input logic e_oe,
                       input logic [7:0] e_xs);
        if (e_oe && !w)
            exp_q.push_back(d);
        addr <= a;
        wd <= d;
        rd <= !w;
        wr <= w;
        cyc(4);
        @(negedge clk_sys_i);
        snap_oe = oe;
        snap_xs = xs_n;
        @(posedge clk_sys_i);
        rd <= 1'b0;
        wr <= 1'b0;
        cyc(5);
        check(snap_oe, e_oe, "data enable");
        check(snap_xs, e_xs, "external strobes");
    endtask

    // Each new read answer takes the oldest note.
    always @(posedge clk_sys_i) begin
        m = (oe === 1'b1 && !prev_oe) || (id_lo_n === 1'b0 && prev_lo) || (id_hi_n === 1'b0 && prev_hi);
        if (m) begin
            q = exp_q.size() ? exp_q.pop_front() : 8'hxx;
            check(oe === 1'b1 ? rdata : id_bus, q, "returned byte");
        end
        prev_oe = (oe === 1'b1);
        prev_lo = (id_lo_n !== 1'b0);
        prev_hi = (id_hi_n !== 1'b0);
    end

    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 4000) begin
            failures++;
            $display("wrong value at %0t: run hung", $time);
            test_done;
        end
    end

    // ------------------------------------------------------------
    // Stimulus
    // ------------------------------------------------------------
    initial begin
        cyc(3);
        rst_i <= 1'b0;
        setup_n <= 1'b0;
        cyc(4);
        v = $random(seed);
        v[0] = 1'b1;
        acc(1'b1, OSR_ADDR_ENABLE, v, 1'b0, 8'hff);
        check(cen, 1'b1, "card enable");
        check({u7, u6, u15}, v[7:1], "user pins");
        acc(1'b0, OSR_ADDR_ENABLE, v, 1'b1, 8'hff);
        acc(1'b1, OSR_ADDR_ENABLE, v ^ 8'h01, 1'b0, 8'hff);
        check(cen, 1'b0, "card disable");
        note("enable");
        v = $random(seed);
        s = $random(seed);
        acc(1'b1, OSR_ADDR_RELOC_A, v, 1'b0, 8'hff);
        acc(1'b1, OSR_ADDR_RELOC_B, s, 1'b0, 8'hff);
        acc(1'b0, OSR_ADDR_RELOC_A, v, 1'b1, 8'hff);
        acc(1'b0, OSR_ADDR_RELOC_B, s, 1'b1, 8'hff);
        aa <= v[7:6];
        cyc(4);
        check(match_n, 1'b0, "match");
        aa <= ~v[7:6];
        cyc(4);
        check(match_n, 1'b1, "no match");
        mode <= 2'h1;
        cyc(2);
        acc(1'b0, OSR_ADDR_RELOC_B, s, 1'b0, 8'hfd);
        acc(1'b1, OSR_ADDR_RELOC_B, s, 1'b0, 8'hfe);
        acc(1'b0, OSR_ADDR_RELOC_A, v, 1'b1, 8'hff);
        note("relocation");
        mode <= 2'h2;
        chrst <= 1'b1;
        cyc(6);
        chrst <= 1'b0;
        cyc(3);
        check({cen, u7, u6, u15}, 8'h00, "cleared pins");
        acc(1'b0, OSR_ADDR_ENABLE, 8'h00, 1'b1, 8'hff);
        for (int i = 0; i < 8; i++)
            acc(i[0], ra[i / 2], 8'h5a, 1'b0, ~(8'h01 << (rb[i / 2] - i[0])));
        xst_n <= 1'b0;
        cyc(3);
        acc(1'b0, OSR_ADDR_STATUS, 8'h80, 1'b1, 8'hff);
        xst_n <= 1'b1;
        cyc(3);
        acc(1'b0, OSR_ADDR_STATUS, 8'hc0, 1'b1, 8'hff);
        note("pin mode 2");
        mode <= 2'h0;
        chrst <= 1'b1;
        cyc(6);
        chrst <= 1'b0;
        cyc(2);
        v = $random(seed);
        acc(1'b1, OSR_ADDR_STATUS, v, 1'b0, 8'hff);
        acc(1'b0, OSR_ADDR_STATUS, {2'b10, v[5:0]}, 1'b1, 8'hff);
        check({oc, oc_oe, arb, fair}, {4'h0, ~v[3:0], 5'h00}, "variant pins");
        acc(1'b0, OSR_ADDR_EXTRA_HI, 8'h00, 1'b0, 8'hff);
        acc(1'b0, 16'h0108, 8'h00, 1'b0, 8'hff);
        setup_n <= 1'b1;
        cyc(3);
        acc(1'b1, OSR_ADDR_ENABLE, 8'h01, 1'b0, 8'hff);
        check(cen, 1'b0, "write outside setup");
        setup_n <= 1'b0;
        cyc(3);
        for (int i = 0; i < 4; i++) begin
            id_rdy <= i[1];
            exp_q.push_back(i[1] ? TB_ID[8 * i[0] +: 8] : 8'h00);
            acc(1'b0, i[0] ? OSR_ADDR_ID_HIGH : OSR_ADDR_ID_LOW, 8'h00, 1'b0, 8'hff);
        end
        note("setup and identifier");
        acc(1'b1, OSR_ADDR_ENABLE, 8'h01, 1'b0, 8'hff);
        err_n <= 1'b0;
        cyc(5);
        check(chk, 1'b1, "channel check");
        err_n <= 1'b1;
        cyc(3);
        acc(1'b0, OSR_ADDR_STATUS, {2'b00, v[5:0]}, 1'b1, 8'hff);
        // Sync ready frees at the command edge, async at the strobe.
        for (int i = 0; i < 2; i++) begin
            acc(1'b1, OSR_ADDR_STATUS, {v[7:6], i[0], v[4:0]}, 1'b0, 8'hff);
            setup_n <= 1'b1;
            ardy_n <= 1'b0;
            cyc(4);
            check(nme, 1'b1, "normal mode");
            cmd_n <= 1'b0;
            cyc(5);
            check(rdy, i[0], "ready after command");
            rstb <= 1'b1;
            cyc(5);
            check(rdy, 1'b1, "ready after strobe");
            {setup_n, ardy_n, cmd_n, rstb} <= 4'h6;
            cyc(4);
        end
        note("error and ready");
        rst_i <= 1'b1;
        cyc(3);
        rst_i <= 1'b0;
        cyc(4);
        acc(1'b0, OSR_ADDR_STATUS, 8'h80, 1'b1, 8'hff);
        acc(1'b0, OSR_ADDR_ENABLE, 8'h00, 1'b1, 8'hff);
        check(exp_q.size(), 0, "unanswered reads");
        note("reset");
        test_done;
    end
endmodule // test_option_select_registers
`default_nettype wire
